// ---- design/soft_strap_port1_led_defaults.v ----
// Soft strap loader for indicator and Port 1 PHY register defaults
`timescale 1ns/100ps
`include "strap_loader_defines.vh"

// Overview of operation
// - Six indicator enable bits load from six enable straps, default one.
// - Two-bit indicator function field loads from function straps, default 00.
// - Auto-crossover strap sets hardware config strap-state bit; pin shared with indicator.
// - Strap-based crossover select uses auto strap combined with manual strap.
// - Auto strap low: manual strap 0 gives MDI, 1 gives MDIX; default 0.
// - Crossover straps ignored in MII PHY, RMII PHY or MII MAC mode.
// - Negotiation strap sets PHY negotiation enable reset value; default 1 in internal PHY.
// - Negotiation strap also shapes speed, duplex, 10BASE-T advert and mode field.
// - Heartbeat test off bit loads from its strap only in MII PHY mode.
// - Heartbeat strap ignored in internal PHY, RMII PHY or MII MAC mode.
// - Straps captured at reset release; EEPROM loader may replace any value.
// - Digital reset or reload without EEPROM restores captured values, no resampling.
module soft_strap_port1_led_defaults #(
    parameter ADDR_W = 8,
    parameter DATA_W = 16
) (
    input  wire                clock_i,
    input  wire                rst_i,
    input  wire                ce_i,
    input  wire [5:0]          indicator_enable_straps_i,
    input  wire [1:0]          indicator_function_straps_i,
    input  wire                port1_indicator_pin_i,
    input  wire                manual_crossover_strap_i,
    input  wire                negotiation_strap_i,
    input  wire                port1_heartbeat_test_off_strap_i,
    input  wire [2:0]          port1_mode_i,
    input  wire                port1_speed_strap_i,
    input  wire                port1_duplex_strap_i,
    input  wire                eeprom_present_i,
    input  wire                eeprom_write_i,
    input  wire [11:0]         eeprom_data_i,
    input  wire                restore_i,
    input  wire [ADDR_W-1:0]   addr_i,
    input  wire [DATA_W-1:0]   wr_data_i,
    input  wire                wr_i,
    input  wire                rd_i,
    output wire [DATA_W-1:0]   rd_data_o,
    output wire [5:0]          indicator_enable_bits_o,
    output wire [1:0]          indicator_function_field_o,
    output wire                phy_negotiation_enable_o,
    output wire                crossover_auto_o,
    output wire                crossover_mdix_o,
    output wire                heartbeat_test_off_bit_o,
    output wire                straps_ready_o
);
    wire [`STRAP_W-1:0] strap_pins;
    wire [`STRAP_W-1:0] active;
    wire                captured;
    wire                load;
    wire                xover_auto;
    wire                xover_mdix;
    wire                internal_phy;

    reg  [5:0]          ind_en_ff;
    reg  [1:0]          ind_fun_ff;
    reg                 auto_state_ff;
    reg                 neg_en_ff;
    reg                 speed_low_ff;
    reg                 bit_a_ff;
    reg                 adv_10fd_ff;
    reg                 adv_10hd_ff;
    reg  [2:0]          phy_mode_ff;
    reg  [1:0]          xsel_ff;
    reg                 hb_off_ff;
    reg                 ready_ff;
    reg  [DATA_W-1:0]   rd_data_ff;
    reg  [DATA_W-1:0]   nxt_rd_data;

    // ==========================================================
    // Strap capture
    assign strap_pins = {port1_heartbeat_test_off_strap_i, negotiation_strap_i,
                         manual_crossover_strap_i, port1_indicator_pin_i,
                         indicator_function_straps_i, indicator_enable_straps_i};
    assign internal_phy = (port1_mode_i == `MODE_INTERNAL_PHY);

    strap_holder #(
        .W (`STRAP_W)
    ) u_holder (
        .clock_i          (clock_i),
        .rst_i            (rst_i),
        .ce_i             (ce_i),
        .strap_pins_i     (strap_pins),
        .reset_value_i    (`STRAP_RESET_VALUE),
        .eeprom_present_i (eeprom_present_i),
        .eeprom_write_i   (eeprom_write_i),
        .eeprom_data_i    (eeprom_data_i),
        .restore_i        (restore_i),
        .active_o         (active),
        .captured_o       (captured),
        .load_o           (load)
    );

    // ==========================================================
    // Crossover decision
    crossover_resolver u_xover (
        .clock_i        (clock_i),
        .rst_i          (rst_i),
        .ce_i           (ce_i),
        .mode_i         (port1_mode_i),
        .select_i       (xsel_ff),
        .auto_strap_i   (active[`STRAP_AUTO_BIT]),
        .manual_strap_i (active[`STRAP_MAN_BIT]),
        .auto_o         (xover_auto),
        .mdix_o         (xover_mdix)
    );

    // ==========================================================
    // Register defaults and software writes
    // A strap load overrides a write in the same cycle, so the defaults always land
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ind_en_ff     <= 6'h3f;
            ind_fun_ff    <= 2'h0;
            auto_state_ff <= 1'b0;
            neg_en_ff     <= 1'b1;
            speed_low_ff  <= 1'b1;
            bit_a_ff      <= 1'b1;
            adv_10fd_ff   <= 1'b1;
            adv_10hd_ff   <= 1'b1;
            phy_mode_ff   <= `MODE_INTERNAL_PHY;
            xsel_ff       <= `XSEL_RESET;
            hb_off_ff     <= 1'b0;
            ready_ff      <= 1'b0;
        end
        else if (ce_i)
        begin
            ready_ff <= captured;
            if (load)
            begin
                ind_en_ff     <= active[`STRAP_EN_MSB:`STRAP_EN_LSB];
                ind_fun_ff    <= active[`STRAP_FUN_MSB:`STRAP_FUN_LSB];
                auto_state_ff <= active[`STRAP_AUTO_BIT];
                // Negotiation only meaningful on the internal PHY
                neg_en_ff     <= internal_phy & active[`STRAP_AN_BIT];
                if (internal_phy && active[`STRAP_AN_BIT])
                begin
                    speed_low_ff <= 1'b1;
                    bit_a_ff     <= 1'b1;
                    adv_10fd_ff  <= 1'b1;
                    adv_10hd_ff  <= 1'b1;
                    phy_mode_ff  <= 3'h7;
                end
                else
                begin
                    speed_low_ff <= port1_speed_strap_i;
                    bit_a_ff     <= port1_duplex_strap_i;
                    adv_10fd_ff  <= ~port1_speed_strap_i & port1_duplex_strap_i;
                    adv_10hd_ff  <= ~port1_speed_strap_i & ~port1_duplex_strap_i;
                    phy_mode_ff  <= {1'b0, port1_speed_strap_i, port1_duplex_strap_i};
                end
                if (port1_mode_i == `MODE_MII_PHY)
                    hb_off_ff <= active[`STRAP_HB_BIT];
                else
                    hb_off_ff <= 1'b0;
            end
            else if (wr_i)
            begin
                case (addr_i)
                    `OFS_INDICATOR_CFG:
                    begin
                        ind_en_ff  <= wr_data_i[5:0];
                        ind_fun_ff <= wr_data_i[`FLD_IND_FUN_LSB+1:`FLD_IND_FUN_LSB];
                    end
                    `OFS_PHY_BASIC_CTRL:
                    begin
                        neg_en_ff    <= wr_data_i[`FLD_BC_NEG_BIT];
                        speed_low_ff <= wr_data_i[`FLD_BC_SPEED_BIT];
                        bit_a_ff     <= wr_data_i[`FLD_BC_DUPLEX_BIT];
                    end
                    `OFS_PHY_NEG_ADVERT:
                    begin
                        adv_10fd_ff <= wr_data_i[`FLD_ADV_10FD_BIT];
                        adv_10hd_ff <= wr_data_i[`FLD_ADV_10HD_BIT];
                    end
                    `OFS_PHY_SPECIAL_CTRL:
                        xsel_ff <= wr_data_i[`FLD_SC_SEL_LSB+1:`FLD_SC_SEL_LSB];
                    `OFS_MEDIA_BASIC_CTRL:
                        hb_off_ff <= wr_data_i[`FLD_MB_HB_BIT];
                    default:
                        ready_ff <= captured;
                endcase
            end
        end
    end

    // ==========================================================
    // Read path, data valid only in the cycle after the strobe
    always @*
    begin
        nxt_rd_data = {DATA_W{1'b0}};
        if (rd_i)
        begin
            case (addr_i)
                `OFS_INDICATOR_CFG:
                begin
                    nxt_rd_data[5:0] = ind_en_ff;
                    nxt_rd_data[`FLD_IND_FUN_LSB+1:`FLD_IND_FUN_LSB] = ind_fun_ff;
                end
                `OFS_HARDWARE_CFG:
                begin
                    nxt_rd_data[`FLD_HW_AUTO_BIT]  = auto_state_ff;
                    nxt_rd_data[`FLD_HW_READY_BIT] = ready_ff;
                end
                `OFS_PHY_BASIC_CTRL:
                begin
                    nxt_rd_data[`FLD_BC_NEG_BIT]    = neg_en_ff;
                    nxt_rd_data[`FLD_BC_SPEED_BIT]  = speed_low_ff;
                    nxt_rd_data[`FLD_BC_DUPLEX_BIT] = bit_a_ff;
                end
                `OFS_PHY_NEG_ADVERT:
                begin
                    nxt_rd_data[`FLD_ADV_10FD_BIT] = adv_10fd_ff;
                    nxt_rd_data[`FLD_ADV_10HD_BIT] = adv_10hd_ff;
                end
                `OFS_PHY_SPECIAL_MODES:
                    nxt_rd_data[`FLD_SM_MODE_LSB+2:`FLD_SM_MODE_LSB] = phy_mode_ff;
                `OFS_PHY_SPECIAL_CTRL:
                begin
                    nxt_rd_data[`FLD_SC_SEL_LSB+1:`FLD_SC_SEL_LSB] = xsel_ff;
                    nxt_rd_data[`FLD_SC_AUTO_BIT] = xover_auto;
                    nxt_rd_data[`FLD_SC_MDIX_BIT] = xover_mdix;
                end
                `OFS_MEDIA_BASIC_CTRL:
                    nxt_rd_data[`FLD_MB_HB_BIT] = hb_off_ff;
                default:
                    nxt_rd_data = {DATA_W{1'b0}};
            endcase
        end
    end

    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            rd_data_ff <= {DATA_W{1'b0}};
        else if (ce_i)
            rd_data_ff <= nxt_rd_data;
    end

    // ==========================================================
    // Outputs
    assign rd_data_o                  = rd_data_ff;
    assign indicator_enable_bits_o    = ind_en_ff;
    assign indicator_function_field_o = ind_fun_ff;
    assign phy_negotiation_enable_o   = neg_en_ff;
    assign crossover_auto_o           = xover_auto;
    assign crossover_mdix_o           = xover_mdix;
    assign heartbeat_test_off_bit_o   = hb_off_ff;
    assign straps_ready_o             = ready_ff;
endmodule // soft_strap_port1_led_defaults

// ---- design/strap_loader_defines.vh ----
// Offsets, field positions, reset values and codes for the soft strap loader
`ifndef STRAP_LOADER_DEFINES_VH
`define STRAP_LOADER_DEFINES_VH

// ==========================================================
// Register offsets
`define OFS_INDICATOR_CFG     8'h00
`define OFS_HARDWARE_CFG      8'h04
`define OFS_PHY_BASIC_CTRL    8'h08
`define OFS_PHY_NEG_ADVERT    8'h0c
`define OFS_PHY_SPECIAL_MODES 8'h10
`define OFS_PHY_SPECIAL_CTRL  8'h14
`define OFS_MEDIA_BASIC_CTRL  8'h18

// ==========================================================
// Soft strap vector layout
`define STRAP_W        12
`define STRAP_EN_LSB   0
`define STRAP_EN_MSB   5
`define STRAP_FUN_LSB  6
`define STRAP_FUN_MSB  7
`define STRAP_AUTO_BIT 8
`define STRAP_MAN_BIT  9
`define STRAP_AN_BIT   10
`define STRAP_HB_BIT   11
// Enables 1, function 00, auto 0, manual 0, negotiation 1, heartbeat 0
`define STRAP_RESET_VALUE 12'h43f

// ==========================================================
// Register field positions
`define FLD_IND_FUN_LSB   8
`define FLD_HW_AUTO_BIT   0
`define FLD_HW_READY_BIT  1
`define FLD_BC_DUPLEX_BIT 8
`define FLD_BC_NEG_BIT    12
`define FLD_BC_SPEED_BIT  13
`define FLD_ADV_10HD_BIT  5
`define FLD_ADV_10FD_BIT  6
`define FLD_SM_MODE_LSB   5
`define FLD_SC_AUTO_BIT   12
`define FLD_SC_MDIX_BIT   13
`define FLD_SC_SEL_LSB    14
`define FLD_MB_HB_BIT     11

// ==========================================================
// Port 1 mode codes
`define MODE_INTERNAL_PHY 3'h7
`define MODE_MII_PHY      3'h1
`define MODE_RMII_PHY     3'h2
`define MODE_MII_MAC      3'h3

// ==========================================================
// Crossover control select codes
`define XSEL_STRAP      2'h0
`define XSEL_FORCE_AUTO 2'h1
`define XSEL_FORCE_MDI  2'h2
`define XSEL_FORCE_MDIX 2'h3
`define XSEL_RESET      2'h0

`endif

// ---- design/strap_holder.v ----
// Strap capture at reset release, loader override and restore
`timescale 1ns/100ps
module strap_holder #(
    parameter W = 12
) (
    input  wire         clock_i,
    input  wire         rst_i,
    input  wire         ce_i,
    input  wire [W-1:0] strap_pins_i,
    input  wire [W-1:0] reset_value_i,
    input  wire         eeprom_present_i,
    input  wire         eeprom_write_i,
    input  wire [W-1:0] eeprom_data_i,
    input  wire         restore_i,
    output wire [W-1:0] active_o,
    output wire         captured_o,
    output wire         load_o
);
    reg [W-1:0] captured_ff;
    reg [W-1:0] active_ff;
    reg         done_ff;
    reg         load_ff;

    // ==========================================================
    // Capture and override
    // Pins are only sampled once; restore reuses the stored copy
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            captured_ff <= {W{1'b0}};
            active_ff   <= {W{1'b0}};
            done_ff     <= 1'b0;
            load_ff     <= 1'b0;
        end
        else if (ce_i)
        begin
            load_ff <= 1'b0;
            if (!done_ff)
            begin
                captured_ff <= strap_pins_i;
                active_ff   <= strap_pins_i;
                done_ff     <= 1'b1;
                load_ff     <= 1'b1;
            end
            else if (eeprom_write_i && eeprom_present_i)
            begin
                active_ff <= eeprom_data_i;
                load_ff   <= 1'b1;
            end
            else if (restore_i && !eeprom_present_i)
            begin
                active_ff <= captured_ff;
                load_ff   <= 1'b1;
            end
        end
    end

    // Before capture the tie-off defaults stand
    assign active_o   = done_ff ? active_ff : reset_value_i;
    assign captured_o = done_ff;
    assign load_o     = load_ff;
endmodule // strap_holder

// ---- design/crossover_resolver.v ----
// Port 1 crossover decision from straps, mode and control select
`timescale 1ns/100ps
`include "strap_loader_defines.vh"
module crossover_resolver (
    input  wire       clock_i,
    input  wire       rst_i,
    input  wire       ce_i,
    input  wire [2:0] mode_i,
    input  wire [1:0] select_i,
    input  wire       auto_strap_i,
    input  wire       manual_strap_i,
    output wire       auto_o,
    output wire       mdix_o
);
    reg auto_ff;
    reg mdix_ff;
    reg nxt_auto;
    reg nxt_mdix;

    // ==========================================================
    // Decision
    always @*
    begin
        nxt_auto = 1'b0;
        nxt_mdix = 1'b0;
        case (select_i)
            `XSEL_STRAP:
            begin
                if (mode_i != `MODE_INTERNAL_PHY)
                begin
                    nxt_auto = 1'b0;
                    nxt_mdix = 1'b0;
                end
                else if (auto_strap_i)
                    nxt_auto = 1'b1;
                else
                    nxt_mdix = manual_strap_i;
            end
            `XSEL_FORCE_AUTO: nxt_auto = 1'b1;
            `XSEL_FORCE_MDI:  nxt_mdix = 1'b0;
            `XSEL_FORCE_MDIX: nxt_mdix = 1'b1;
            default:          nxt_auto = 1'b0;
        endcase
    end

    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            auto_ff <= 1'b0;
            mdix_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            auto_ff <= nxt_auto;
            mdix_ff <= nxt_mdix;
        end
    end

    assign auto_o = auto_ff;
    assign mdix_o = mdix_ff;
endmodule // crossover_resolver

// ---- testbench/soft_strap_port1_led_defaults_sva.sv ----
// Assertions for the soft strap loader
`timescale 1ns/100ps
module soft_strap_port1_led_defaults_sva #(
    parameter ADDR_W = 8,
    parameter DATA_W = 16
) (
    input wire              clock_i,
    input wire              rst_i,
    input wire              ce_i,
    input wire [2:0]        port1_mode_i,
    input wire              eeprom_present_i,
    input wire              eeprom_write_i,
    input wire [11:0]       eeprom_data_i,
    input wire              restore_i,
    input wire [ADDR_W-1:0] addr_i,
    input wire              rd_i,
    input wire [DATA_W-1:0] rd_data_o,
    input wire [5:0]        indicator_enable_bits_o,
    input wire [1:0]        indicator_function_field_o,
    input wire              phy_negotiation_enable_o,
    input wire              heartbeat_test_off_bit_o,
    input wire              straps_ready_o
);
    // ==========================================================
    // Helpers
    wire       ld     = eeprom_write_i && eeprom_present_i && ce_i && straps_ready_o;
    wire [5:0] ee_en  = eeprom_data_i[5:0];
    wire [1:0] ee_fun = eeprom_data_i[7:6];
    wire       ee_neg = eeprom_data_i[10];
    wire       ee_hb  = eeprom_data_i[11];

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // ==========================================================
    // Properties
    en_load_a: assert property (ld ##1 ce_i |=> indicator_enable_bits_o == $past(ee_en, 2))
        else $error("enable bits not loaded");
    fun_load_a: assert property (ld ##1 ce_i |=> indicator_function_field_o == $past(ee_fun, 2))
        else $error("function field not loaded");
    neg_load_a: assert property (ld ##1 ce_i |=> phy_negotiation_enable_o ==
        ($past(ee_neg, 2) && $past(port1_mode_i) == 3'h7)) else $error("negotiation bit wrong");
    hb_load_a: assert property (ld ##1 ce_i |=> heartbeat_test_off_bit_o ==
        ($past(ee_hb, 2) && $past(port1_mode_i) == 3'h1)) else $error("heartbeat bit wrong");
    rd_idle_a: assert property (ce_i && !rd_i |=> rd_data_o == 16'h0000)
        else $error("read data not idle");
    rd_ind_a: assert property (rd_i && ce_i && addr_i == 8'h00 |=> rd_data_o == {6'h00,
        $past(indicator_function_field_o), 2'h0, $past(indicator_enable_bits_o)})
        else $error("indicator read wrong");
    rd_gap_a: assert property (rd_i && ce_i && addr_i == 8'h1c |=> rd_data_o == 16'h0000)
        else $error("unmapped read not zero");
    ready_late_a: assert property (!straps_ready_o ##1 ce_i ##1 ce_i |=> straps_ready_o)
        else $error("ready not raised");
    freeze_a: assert property (!ce_i |=> $stable(rd_data_o) && $stable(indicator_enable_bits_o))
        else $error("state moved while disabled");

    cover property (ld);
    cover property (restore_i && !eeprom_present_i && ce_i);
    cover property (rd_i && addr_i == 8'h1c);
endmodule // soft_strap_port1_led_defaults_sva

bind soft_strap_port1_led_defaults soft_strap_port1_led_defaults_sva #(
    .ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.clock_i, .rst_i, .ce_i, .port1_mode_i,
    .eeprom_present_i, .eeprom_write_i, .eeprom_data_i, .restore_i, .addr_i, .rd_i,
    .rd_data_o, .indicator_enable_bits_o, .indicator_function_field_o,
    .phy_negotiation_enable_o, .heartbeat_test_off_bit_o, .straps_ready_o);

// ---- testbench/soft_strap_port1_led_defaults_bench.sv ----
// Self-checking bench for the soft strap loader
`timescale 1ns/100ps
module soft_strap_port1_led_defaults_bench;
    reg         clock_i = 1'b0;
    reg         rst_i   = 1'b1;
    reg         ce_i    = 1'b1;
    reg  [5:0]  en_s    = 6'h2a;
    reg  [1:0]  fun_s   = 2'h2;
    reg         auto_s  = 1'b1;
    reg         man_s   = 1'b1;
    reg         neg_s   = 1'b1;
    reg  [2:0]  mode    = 3'h7;
    reg         present = 1'b1;
    reg         ee_wr   = 1'b0;
    reg  [11:0] ee_data = 12'h000;
    reg         restore = 1'b0;
    reg  [7:0]  addr    = 8'h00;
    reg  [15:0] wdata   = 16'h0000;
    reg         wr      = 1'b0;
    reg         rd      = 1'b0;
    reg  [15:0] got;
    wire [15:0] rdata;
    wire [5:0]  en_o;
    wire [1:0]  fun_o;
    wire        neg_o;
    wire        xa_o;
    wire        xm_o;
    wire        hb_o;
    wire        rdy_o;
    // Packed view: [5:0] enables, [7:6] function, [8] neg, [9] heartbeat, [10] auto, [11] mdix
    wire [15:0] outs    = {4'h0, xm_o, xa_o, hb_o, neg_o, fun_o, en_o};
    integer     failures    = 0;
    integer     check_count = 0;
    integer     i;

    soft_strap_port1_led_defaults uut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
        .indicator_enable_straps_i(en_s), .indicator_function_straps_i(fun_s),
        .port1_indicator_pin_i(auto_s), .manual_crossover_strap_i(man_s),
        .negotiation_strap_i(neg_s), .port1_heartbeat_test_off_strap_i(1'b1),
        .port1_mode_i(mode), .port1_speed_strap_i(1'b1), .port1_duplex_strap_i(1'b0),
        .eeprom_present_i(present), .eeprom_write_i(ee_wr), .eeprom_data_i(ee_data),
        .restore_i(restore), .addr_i(addr), .wr_data_i(wdata), .wr_i(wr), .rd_i(rd),
        .rd_data_o(rdata), .indicator_enable_bits_o(en_o), .indicator_function_field_o(fun_o),
        .phy_negotiation_enable_o(neg_o), .crossover_auto_o(xa_o), .crossover_mdix_o(xm_o),
        .heartbeat_test_off_bit_o(hb_o), .straps_ready_o(rdy_o));

    initial
    begin
        forever #12.5 clock_i = ~clock_i;
    end

    // ==========================================================
    // Tasks
    task check(input [15:0] g, input [15:0] e, input [15:0] m);
    begin
        check_count = check_count + 1;
        if ((g & m) !== (e & m))
        begin
            failures = failures + 1;
            $display("Error at %0t: got %h expected %h", $time, g & m, e & m);
        end
    end
    endtask

    // Loader strobe, then wait past the crossover path, which updates in the same cycle as the other outputs
    task load(input [11:0] d, input r);
    begin
        @(posedge clock_i);
        ee_wr   <= !r;
        restore <= r;
        ee_data <= d;
        @(posedge clock_i);
        ee_wr   <= 1'b0;
        restore <= 1'b0;
        repeat (3) @(posedge clock_i);
        #1;
    end
    endtask

    task bus_wr(input [7:0] a, input [15:0] d);
    begin
        @(posedge clock_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock_i);
        wr    <= 1'b0;
        #1;
    end
    endtask

    task bus_rd(input [7:0] a);
    begin
        @(posedge clock_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock_i);
        rd   <= 1'b0;
        #1;
        got = rdata;
    end
    endtask

    task summarize;
    begin
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask

    // ==========================================================
    // Sequence
    initial
    begin
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        i = 0;
        while (rdy_o !== 1'b1 && i < 20)
        begin
            @(posedge clock_i);
            i = i + 1;
        end
        if (rdy_o !== 1'b1)
        begin
            failures = failures + 1;
            summarize;
        end
        else
        begin
            // Bounded wait above, then let the crossover path settle
            repeat (2) @(posedge clock_i);
            #1;
            check(outs, 16'h05aa, 16'h07ff);
            bus_rd(8'h00); check(got, 16'h022a, 16'hffff);
            bus_rd(8'h04); check(got, 16'h0003, 16'h0003);
            bus_rd(8'h08); check(got, 16'h3100, 16'h3100);
            bus_rd(8'h0c); check(got, 16'h0060, 16'h0060);
            bus_rd(8'h10); check(got, 16'h00e0, 16'h00e0);
            bus_rd(8'h14); check(got, 16'h1000, 16'hd000);
            $display("test capture done");
            load(12'ha55, 1'b0); check(outs, 16'h0855, 16'h0fff);
            bus_rd(8'h04); check(got, 16'h0000, 16'h0001);
            load(12'h855, 1'b0); check(outs, 16'h0055, 16'h0fff);
            $display("test loader done");
            for (i = 1; i < 4; i = i + 1)
            begin
                @(posedge clock_i);
                mode <= i[2:0];
                load(12'hf3f, 1'b0);
                check(outs, (i == 1) ? 16'h023f : 16'h003f, 16'h0fff);
            end
            // Outside the internal PHY the speed and duplex straps shape the defaults
            bus_rd(8'h08); check(got, 16'h2000, 16'h3100);
            bus_rd(8'h0c); check(got, 16'h0000, 16'h0060);
            bus_rd(8'h10); check(got, 16'h0040, 16'h00e0);
            bus_rd(8'h14); check(got, 16'h0000, 16'h3000);
            bus_wr(8'h14, 16'hc000);
            bus_rd(8'h14); check(got, 16'he000, 16'hf000);
            bus_wr(8'h14, 16'h0000);
            $display("test modes done");
            // Pins move after capture; a restore must not pick them up
            load(12'h000, 1'b1); check(outs, 16'h003f, 16'h0fff);
            @(posedge clock_i);
            present <= 1'b0;
            en_s    <= 6'h15;
            fun_s   <= 2'h1;
            auto_s  <= 1'b0;
            man_s   <= 1'b0;
            neg_s   <= 1'b0;
            load(12'h000, 1'b0); check(outs, 16'h003f, 16'h0fff);
            @(posedge clock_i);
            mode <= 3'h7;
            load(12'h000, 1'b1); check(outs, 16'h05aa, 16'h07ff);
            $display("test restore done");
            bus_wr(8'h00, 16'h0105); check(outs, 16'h0045, 16'h00ff);
            bus_rd(8'h00); check(got, 16'h0105, 16'hffff);
            bus_wr(8'h04, 16'h0000);
            bus_rd(8'h04); check(got, 16'h0001, 16'h0001);
            bus_rd(8'h1c); check(got, 16'h0000, 16'hffff);
            @(posedge clock_i);
            // A write while frozen must be dropped
            ce_i  <= 1'b0;
            addr  <= 8'h00;
            wdata <= 16'h0000;
            wr    <= 1'b1;
            @(posedge clock_i);
            wr    <= 1'b0;
            repeat (2) @(posedge clock_i);
            ce_i <= 1'b1;
            #1;
            check(outs, 16'h0045, 16'h00ff);
            $display("test bus done");
            summarize;
        end
    end
endmodule // soft_strap_port1_led_defaults_bench
